// file: include/scs_pkg.sv
// Purpose: shared constants for the servo command scaling block
// Assumes: 20 MHz mclk_i, 16-bit register port, 4-bit register address
// Notes:   register offsets are word indices on the plain register port
//
// Overview of operation
// R1: output encoder counts equal input pulses times numerator over denominator, 10000 per rev.
// R2: numerators and denominator accept any value, giving any gear ratio; the gear takes a denominator of 0 as 1.
// R3: host should keep the gear ratio between 1/50 and 50; not enforced.
// R4: motor speed tracks pulse frequency times ratio; 500 kHz at unity is 3000 rpm.
// R5: dynamic gear enable, default off; when 1 the select input may switch numerators.
// R6: select off uses numerator one, select on numerator two, same denominator.
// R7: host sends no pulses within 10 ms either side of a select change.
// R8: speed mode follows analog command magnitude, reversing when the command is negative.
// R9: zero speed clamp input forces the speed command to zero.
// R10: a zero offset trim, default zero, is added to the analog command.
// R11: analog command is scaled by a gain setting, default 300.
// R12: invert setting, default 0, reverses analog command polarity before use.
// R13: speed source select setting defaults to 1.
// R14: source select 0 uses the preset speed, 1 the analog command.
// R15: control method 0 is position, 1 is speed, 6 is torque.
// R16: travel limit ignore setting, default 0; when 1 limit inputs are disregarded.
// R17: motor energised and run lamp lit only with servo enable and no alarm.
// R18: gear remainder carried between pulses so no motion is lost or gained.
// R19: a select change takes effect only at a pulse boundary with nothing pending.
`default_nettype none

package scs_pkg;

  // ---------------------------------------------------------------
  // register port geometry
  // ---------------------------------------------------------------
  localparam int unsigned SCS_DW = 16;
  localparam int unsigned SCS_AW = 4;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] SCS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SCS_ADDR_NUM1 = 4'h1;
  localparam logic [3:0] SCS_ADDR_DEN = 4'h2;
  localparam logic [3:0] SCS_ADDR_NUM2 = 4'h3;
  localparam logic [3:0] SCS_ADDR_GAIN = 4'h4;
  localparam logic [3:0] SCS_ADDR_TRIM = 4'h5;
  localparam logic [3:0] SCS_ADDR_PRESET = 4'h6;
  localparam logic [3:0] SCS_ADDR_STATUS = 4'h8;
  localparam logic [3:0] SCS_ADDR_POSCNT = 4'h9;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned SCS_CTRL_METHOD_LSB = 0;
  localparam int unsigned SCS_CTRL_DYN_GEAR = 3;
  localparam int unsigned SCS_CTRL_INVERT = 4;
  localparam int unsigned SCS_CTRL_SRC_SEL = 5;
  localparam int unsigned SCS_CTRL_LIM_IGN = 6;
  localparam logic [15:0] SCS_CTRL_MASK = 16'h007f;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int unsigned SCS_STAT_MOTOR = 0;
  localparam int unsigned SCS_STAT_GSEL = 1;
  localparam int unsigned SCS_STAT_CLAMP = 2;
  localparam int unsigned SCS_STAT_BUSY = 3;
  localparam int unsigned SCS_STAT_FLIM = 4;
  localparam int unsigned SCS_STAT_RLIM = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SCS_RST_CTRL = 16'h0020;
  localparam logic [15:0] SCS_RST_NUM1 = 16'h0001;
  localparam logic [15:0] SCS_RST_DEN = 16'h0001;
  localparam logic [15:0] SCS_RST_NUM2 = 16'h0001;
  localparam logic [15:0] SCS_RST_GAIN = 16'h012c;
  localparam logic [15:0] SCS_RST_TRIM = 16'h0000;
  localparam logic [15:0] SCS_RST_PRESET = 16'h0000;

  // ---------------------------------------------------------------
  // scaling constants
  // ---------------------------------------------------------------
  localparam int unsigned SCS_COUNTS_PER_REV = 10000;
  localparam int unsigned SCS_GAIN_SHIFT = 8;
  localparam int unsigned SCS_ACC_W = 24;

  // ---------------------------------------------------------------
  // control methods
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SCS_MODE_POS = 3'b000,
    SCS_MODE_SPEED = 3'b001,
    SCS_MODE_TORQUE = 3'b110
  } scs_mode_e;

endpackage : scs_pkg

`default_nettype wire

// file: logic/scs_gear_div.sv
// Purpose: electronic gear, turns command pulses into encoder counts
// Assumes: pulse_i is a one-cycle strobe on mclk_i
// Notes:   counts leave at most every other cycle so each has a low phase
`default_nettype none

module scs_gear_div
  import scs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // command side
  input wire logic pulse_i,
  input wire logic dir_i,
  input wire logic [15:0] num1_i,
  input wire logic [15:0] num2_i,
  input wire logic [15:0] den_i,
  input wire logic dyn_en_i,
  input wire logic sel_i,
  // count side
  output logic count_o,
  output logic dir_o,
  output logic sel_o,
  output logic busy_o
);

  typedef struct packed {
    logic [SCS_ACC_W-1:0] acc;
    logic sel;
    logic cnt;
    logic dir;
  } scs_gear_s;

  scs_gear_s st_ff;
  scs_gear_s nxt_st;
  logic [SCS_ACC_W-1:0] den_e;
  logic [SCS_ACC_W-1:0] num_e;
  logic emit;

  // remainder accumulator: add numerator per pulse, take denominator per count
  always_comb begin
    nxt_st = st_ff;
    den_e = (den_i == 16'h0000) ? 24'h000001 : {8'h00, den_i};
    num_e = (dyn_en_i && st_ff.sel) ? {8'h00, num2_i} : {8'h00, num1_i}; // R5 R6
    emit = !st_ff.cnt && (st_ff.acc >= den_e);
    nxt_st.acc = st_ff.acc + (pulse_i ? num_e : 24'h000000)
                 - (emit ? den_e : 24'h000000); // R1 R2 R18
    nxt_st.cnt = emit;
    if (pulse_i) begin
      nxt_st.dir = dir_i;
    end
    // select only moves when nothing is owed and no pulse is arriving
    if (!pulse_i && !emit && (st_ff.acc < den_e)) begin
      nxt_st.sel = sel_i; // R19
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_o = st_ff.cnt;
  assign dir_o = st_ff.dir;
  assign sel_o = st_ff.sel;
  assign busy_o = (st_ff.acc >= den_e);

  step_gap_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R1
    count_o |=> !count_o) else $error("gear count held two cycles");

  emit_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R18
    !count_o && (st_ff.acc >= den_e) && !pulse_i |=>
      count_o && (st_ff.acc == $past(st_ff.acc) - $past(den_e)))
    else $error("owed count not emitted or remainder wrong");

  sel_boundary_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
    (st_ff.sel != $past(st_ff.sel)) |-> ($past(st_ff.acc) < $past(den_e)) && !$past(pulse_i))
    else $error("gear select moved mid pulse");

endmodule : scs_gear_div

`default_nettype wire

// file: logic/servo_command_scaling.sv
// Purpose: command conditioning for a servo drive, position and speed paths
// Assumes: pins are asynchronous to mclk_i; adc and alarm come from mclk_i logic
// Notes:   register port reads answer one cycle after the strobe
//
// The implementer's own choices: the register addresses and strobed register access.
`default_nettype none

module servo_command_scaling (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [scs_pkg::SCS_AW-1:0] addr_i,
  input wire logic [scs_pkg::SCS_DW-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [scs_pkg::SCS_DW-1:0] rd_data_o,
  // command pins from the host controller
  input wire logic cmd_pulse_i,
  input wire logic cmd_dir_i,
  input wire logic gear_select_input_i,
  input wire logic zero_speed_clamp_input_i,
  input wire logic servo_enable_input_i,
  input wire logic fwd_limit_i,
  input wire logic rev_limit_i,
  // on-chip inputs
  input wire logic alarm_i,
  input wire logic [15:0] adc_speed_i,
  input wire logic adc_valid_i,
  // drive outputs
  output logic pos_step_o,
  output logic pos_dir_o,
  output logic [15:0] speed_mag_o,
  output logic speed_rev_o,
  output logic motor_on_o,
  output logic run_led_o
);
  import scs_pkg::*;

  // ---------------------------------------------------------------
  // pin synchroniser indices
  // ---------------------------------------------------------------
  localparam int unsigned PIN_PULSE = 0;
  localparam int unsigned PIN_DIR = 1;
  localparam int unsigned PIN_GSEL = 2;
  localparam int unsigned PIN_CLAMP = 3;
  localparam int unsigned PIN_SON = 4;
  localparam int unsigned PIN_FLIM = 5;
  localparam int unsigned PIN_RLIM = 6;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic pulse_d;
    logic [15:0] ctrl;
    logic [15:0] num1;
    logic [15:0] den;
    logic [15:0] num2;
    logic [15:0] gain;
    logic [15:0] trim;
    logic [15:0] preset;
    logic [15:0] rdata;
    logic [15:0] poscnt;
    logic [15:0] speed_mag;
    logic speed_rev;
    logic step;
    logic dir;
    logic motor;
  } scs_state_s;

  scs_state_s st_ff;
  scs_state_s nxt_st;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // clip a wide signed product to 16-bit signed range
  function automatic logic [15:0] scs_sat16(input logic signed [34:0] v);
    logic [15:0] r;
    if (v > 35'sd32767) begin
      r = 16'h7fff;
    end else if (v < -35'sd32768) begin
      r = 16'h8000;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction : scs_sat16

  // ---------------------------------------------------------------
  // decode of settings and synchronised pins
  // ---------------------------------------------------------------
  logic [2:0] mode;
  logic lim_ign;
  logic fwd_block;
  logic rev_block;
  logic pulse_edge;
  logic gear_pulse;
  logic son_ok;
  logic g_count;
  logic g_dir;
  logic g_sel;
  logic g_busy;
  logic signed [16:0] src;
  logic signed [16:0] pol;
  logic signed [17:0] sum;
  logic signed [34:0] prod;
  logic signed [34:0] scaled;
  logic [15:0] sat;
  logic [15:0] status;

  // pin levels are only read from the second synchroniser stage
  always_comb begin
    mode = st_ff.ctrl[SCS_CTRL_METHOD_LSB +: 3]; // R15
    lim_ign = st_ff.ctrl[SCS_CTRL_LIM_IGN];
    fwd_block = st_ff.sync2[PIN_FLIM] && !lim_ign; // R16
    rev_block = st_ff.sync2[PIN_RLIM] && !lim_ign; // R16
    pulse_edge = st_ff.sync2[PIN_PULSE] && !st_ff.pulse_d;
    son_ok = st_ff.sync2[PIN_SON] && !alarm_i; // R17
    // pulses reach the gear only in position mode with the motor live
    gear_pulse = pulse_edge && (mode == SCS_MODE_POS) && st_ff.motor // R15
                 && !(st_ff.sync2[PIN_DIR] ? fwd_block : rev_block);
  end

  // ---------------------------------------------------------------
  // electronic gear
  // ---------------------------------------------------------------
  scs_gear_div u_gear (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pulse_i(gear_pulse),
    .dir_i(st_ff.sync2[PIN_DIR]),
    .num1_i(st_ff.num1),
    .num2_i(st_ff.num2),
    .den_i(st_ff.den),
    .dyn_en_i(st_ff.ctrl[SCS_CTRL_DYN_GEAR]),
    .sel_i(st_ff.sync2[PIN_GSEL]),
    .count_o(g_count),
    .dir_o(g_dir),
    .sel_o(g_sel),
    .busy_o(g_busy)
  );

  // ---------------------------------------------------------------
  // speed path arithmetic
  // ---------------------------------------------------------------

  // source, polarity, trim, gain, saturate
  always_comb begin
    src = st_ff.ctrl[SCS_CTRL_SRC_SEL] ? {adc_speed_i[15], adc_speed_i} // R13 R14
                                       : {st_ff.preset[15], st_ff.preset};
    pol = st_ff.ctrl[SCS_CTRL_INVERT] ? -src : src; // R12
    sum = {pol[16], pol} + {{2{st_ff.trim[15]}}, st_ff.trim}; // R10
    prod = sum * $signed({1'b0, st_ff.gain}); // R11
    scaled = prod >>> SCS_GAIN_SHIFT;
    sat = scs_sat16(scaled);
  end

  // status word assembled from live state
  always_comb begin
    status = 16'h0000;
    status[SCS_STAT_MOTOR] = st_ff.motor;
    status[SCS_STAT_GSEL] = g_sel;
    status[SCS_STAT_CLAMP] = st_ff.sync2[PIN_CLAMP];
    status[SCS_STAT_BUSY] = g_busy;
    status[SCS_STAT_FLIM] = st_ff.sync2[PIN_FLIM];
    status[SCS_STAT_RLIM] = st_ff.sync2[PIN_RLIM];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // two-stage pin synchroniser and pulse edge history
    nxt_st.sync1 = {rev_limit_i, fwd_limit_i, servo_enable_input_i,
                    zero_speed_clamp_input_i, gear_select_input_i, cmd_dir_i,
                    cmd_pulse_i};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.pulse_d = st_ff.sync2[PIN_PULSE];

    // register writes
    if (wr_i) begin
      case (addr_i)
        SCS_ADDR_CTRL: nxt_st.ctrl = wr_data_i & SCS_CTRL_MASK;
        SCS_ADDR_NUM1: nxt_st.num1 = wr_data_i; // R2
        SCS_ADDR_DEN: nxt_st.den = wr_data_i; // R2
        SCS_ADDR_NUM2: nxt_st.num2 = wr_data_i; // R2
        SCS_ADDR_GAIN: nxt_st.gain = wr_data_i;
        SCS_ADDR_TRIM: nxt_st.trim = wr_data_i;
        SCS_ADDR_PRESET: nxt_st.preset = wr_data_i;
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end

    // read data stands for one cycle only, zero otherwise
    nxt_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        SCS_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
        SCS_ADDR_NUM1: nxt_st.rdata = st_ff.num1;
        SCS_ADDR_DEN: nxt_st.rdata = st_ff.den;
        SCS_ADDR_NUM2: nxt_st.rdata = st_ff.num2;
        SCS_ADDR_GAIN: nxt_st.rdata = st_ff.gain;
        SCS_ADDR_TRIM: nxt_st.rdata = st_ff.trim;
        SCS_ADDR_PRESET: nxt_st.rdata = st_ff.preset;
        SCS_ADDR_STATUS: nxt_st.rdata = status;
        SCS_ADDR_POSCNT: nxt_st.rdata = st_ff.poscnt;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end

    // motor enable and run lamp
    nxt_st.motor = son_ok; // R17

    // encoder count stream, one count per scaled step
    nxt_st.step = g_count; // R1 R4
    nxt_st.dir = g_dir;
    if (g_count) begin
      nxt_st.poscnt = g_dir ? st_ff.poscnt + 16'h0001 : st_ff.poscnt - 16'h0001;
    end

    // speed command: refreshed per sample, forced to zero when not allowed
    if (adc_valid_i || !st_ff.ctrl[SCS_CTRL_SRC_SEL]) begin
      nxt_st.speed_rev = sat[15]; // R8
      nxt_st.speed_mag = sat[15] ? (16'h0000 - sat) : sat; // R8
      if ((sat[15] && rev_block) || (!sat[15] && fwd_block)) begin
        nxt_st.speed_mag = 16'h0000; // R16
        nxt_st.speed_rev = 1'b0; // no reverse flag on a stopped axis
      end
    end
    if ((mode != SCS_MODE_SPEED) || !son_ok || st_ff.sync2[PIN_CLAMP]) begin
      nxt_st.speed_mag = 16'h0000; // R9 R15
      nxt_st.speed_rev = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.ctrl <= SCS_RST_CTRL; // R5 R12 R13 R15 R16
      st_ff.num1 <= SCS_RST_NUM1;
      st_ff.den <= SCS_RST_DEN;
      st_ff.num2 <= SCS_RST_NUM2;
      st_ff.gain <= SCS_RST_GAIN; // R11
      st_ff.trim <= SCS_RST_TRIM; // R10
      st_ff.preset <= SCS_RST_PRESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data_o = st_ff.rdata;
  assign pos_step_o = st_ff.step;
  assign pos_dir_o = st_ff.dir;
  assign speed_mag_o = st_ff.speed_mag;
  assign speed_rev_o = st_ff.speed_rev;
  assign motor_on_o = st_ff.motor;
  assign run_led_o = st_ff.motor;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  reset_ctrl_a: assert property (@(posedge mclk_i) // R13
    sys_rst_i |=> (rd_data_o == 16'h0000) && (st_ff.ctrl == 16'h0020)
      && (st_ff.gain == 16'h012c)) else $error("bad reset settings");

  alarm_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
    alarm_i || !st_ff.sync2[PIN_SON] |=> !motor_on_o && !run_led_o)
    else $error("motor live during alarm or without enable");

  clamp_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R9
    st_ff.sync2[PIN_CLAMP] |=> (speed_mag_o == 16'h0000))
    else $error("speed not clamped");

  rd_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && (addr_i == SCS_ADDR_NUM1) |=> rd_data_o == $past(st_ff.num1) ##1
      (rd_data_o == 16'h0000 || $past(rd_i))) else $error("read data wrong");

  torque_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R15
    (mode != SCS_MODE_POS)[*3] |-> !pos_step_o)
    else $error("steps outside position mode");

  speed_sign_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R8
    speed_rev_o |-> (speed_mag_o != 16'h0000 || $past(sat) == 16'h0000)
      && (mode == SCS_MODE_SPEED || $past(mode) == SCS_MODE_SPEED))
    else $error("reverse flag without speed mode");

  limit_stop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R16
    adc_valid_i && fwd_block && !sat[15] |=> (speed_mag_o == 16'h0000))
    else $error("speed commanded into a blocked limit");

endmodule : servo_command_scaling

`default_nettype wire

// file: test/scs_host_model.sv
// Purpose: host motion controller model driving the step, direction and select pins
// Assumes: 20 MHz mclk_i; the pins are synchronised inside the block
// Notes:   pulses are high 2 cycles and low for a chosen span, so fast and slow hosts
`default_nettype none

module scs_host_model #(
  parameter int GUARD_CYC = 200000  // quiet span around a select change, 10 ms at 20 MHz
) (
  // clock
  input wire logic mclk_i,
  // pins towards the drive
  output logic cmd_pulse_o,
  output logic cmd_dir_o,
  output logic gear_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int quiet = 0;

  initial begin
    cmd_pulse_o = 1'b0;
    cmd_dir_o = 1'b1;
    gear_sel_o = 1'b0;
  end

  // cycles since the step pin was last high
  always @(posedge mclk_i) begin
    quiet <= cmd_pulse_o ? 0 : quiet + 1;
  end

  // burst of n pulses; direction settles two cycles before the first edge
  task automatic send(input int n, input logic dir, input int low);
    @(posedge mclk_i);
    cmd_dir_o <= dir;
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      cmd_pulse_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      cmd_pulse_o <= 1'b0;
      repeat (low) @(posedge mclk_i);
    end
  endtask : send

  // select change with no pulse in the guard span before or after it
  task automatic switch_sel(input logic v);
    while (quiet < GUARD_CYC) @(posedge mclk_i);
    gear_sel_o <= v;
    repeat (GUARD_CYC) @(posedge mclk_i);
  endtask : switch_sel
endmodule : scs_host_model

`default_nettype wire

// file: test/servo_command_scaling_bench.sv
// Purpose: self-checking bench for the servo command scaling block
// Assumes: 20 MHz mclk_i, host model on the step pins, short select guard
// Notes:   table rows first, then reset, gear switch, clamp, enable and limit cases
`default_nettype none

module servo_command_scaling_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import scs_pkg::*;

  typedef struct {
    logic kind;  // 0 gear row, 1 speed row
    logic [15:0] ctrl, a, b, c;  // gear: num den pulses; speed: gain trim command
    logic dir;
    int exp;
  } scs_row_s;

  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clamp_i = 1'b0;
  logic son_i = 1'b1;
  logic fwd_lim_i = 1'b0;
  logic rev_lim_i = 1'b0;
  logic alarm_i = 1'b0;
  logic [15:0] adc_speed_i = 16'h0000;
  logic adc_valid_i = 1'b0;
  wire logic [15:0] rd_data_o, speed_mag_o;
  wire logic pos_step_o, pos_dir_o, speed_rev_o, motor_on_o, run_led_o;
  wire logic cmd_pulse, cmd_dir, gear_sel;
  int failures = 0;
  int checks = 0;
  int pos_cnt = 0;

  scs_row_s rows[14] = '{
    '{1'b0, 16'h0020, 16'd1, 16'd1, 16'd10, 1'b1, 10},
    '{1'b0, 16'h0020, 16'd2, 16'd1, 16'd5, 1'b1, 10},
    '{1'b0, 16'h0020, 16'd10, 16'd3, 16'd3, 1'b1, 10},
    '{1'b0, 16'h0020, 16'd25, 16'd2, 16'd8, 1'b1, 100},
    '{1'b0, 16'h0020, 16'd1, 16'd2, 16'd20, 1'b1, 10},
    '{1'b0, 16'h0020, 16'd20, 16'd3, 16'd10, 1'b0, -66},
    '{1'b0, 16'h0020, 16'd30, 16'd4, 16'd4, 1'b1, 30},
    '{1'b1, 16'h0021, 16'd300, 16'h0000, 16'h0100, 1'b0, 300},
    '{1'b1, 16'h0021, 16'd300, 16'h0000, 16'hfe00, 1'b0, -600},
    '{1'b1, 16'h0031, 16'd300, 16'h0000, 16'h0100, 1'b0, -300},
    '{1'b1, 16'h0021, 16'd300, 16'h000a, 16'hfff6, 1'b0, 0},
    '{1'b1, 16'h0021, 16'd512, 16'h0000, 16'h7000, 1'b0, 32767},
    '{1'b1, 16'h0001, 16'd256, 16'h0000, 16'd100, 1'b0, 100},
    '{1'b1, 16'h0021, 16'h0080, 16'h0005, 16'h000a, 1'b0, 7}
  };
  logic [3:0] ra[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha};
  logic [15:0] rv[8] = '{16'h0020, 16'h0001, 16'h0001, 16'h0001, 16'h012c, 16'h0, 16'h0, 16'h0};

  always #25 mclk_i = ~mclk_i;

  // signed tally of encoder counts leaving the gear
  always @(posedge mclk_i) begin
    if (pos_step_o === 1'b1) pos_cnt <= pos_cnt + (pos_dir_o ? 1 : -1);
  end

  scs_host_model #(.GUARD_CYC(20)) i_scs_host_model (
    .mclk_i(mclk_i), .cmd_pulse_o(cmd_pulse), .cmd_dir_o(cmd_dir), .gear_sel_o(gear_sel));

  servo_command_scaling i_servo_command_scaling (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .cmd_pulse_i(cmd_pulse),
    .cmd_dir_i(cmd_dir), .gear_select_input_i(gear_sel), .zero_speed_clamp_input_i(clamp_i),
    .servo_enable_input_i(son_i), .fwd_limit_i(fwd_lim_i), .rev_limit_i(rev_lim_i),
    .alarm_i(alarm_i), .adc_speed_i(adc_speed_i), .adc_valid_i(adc_valid_i),
    .pos_step_o(pos_step_o), .pos_dir_o(pos_dir_o), .speed_mag_o(speed_mag_o),
    .speed_rev_o(speed_rev_o), .motor_on_o(motor_on_o), .run_led_o(run_led_o));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(nm, 32'(exp), 32'(rd_data_o));
  endtask : rd

  task automatic do_reset();
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    pos_cnt <= 0;
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  task automatic adc(input logic [15:0] v);
    @(posedge mclk_i);
    adc_speed_i <= v;
    adc_valid_i <= 1'b1;
    @(posedge mclk_i);
    adc_valid_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : adc

  // wait until no count has left for 12 cycles
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 12; i++) begin
      @(posedge mclk_i);
      q = (pos_step_o === 1'b1) ? 0 : q + 1;
    end
    @(negedge mclk_i);
  endtask : settle

  task automatic burst(input int n, input logic dir, input int exp, input string nm);
    i_scs_host_model.send(n, dir, 3);
    settle();
    chk(nm, 32'(exp), 32'(pos_cnt));
  endtask : burst

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int e;
    for (int r = 0; r < 14; r++) begin
      do_reset();
      e = rows[r].exp;
      if (rows[r].kind == 1'b0) begin
        wr(SCS_ADDR_NUM1, rows[r].a);
        wr(SCS_ADDR_DEN, rows[r].b);
        burst(rows[r].c, rows[r].dir, e, "gear count");
      end else begin
        wr(SCS_ADDR_CTRL, rows[r].ctrl);
        wr(SCS_ADDR_GAIN, rows[r].a);
        wr(SCS_ADDR_TRIM, rows[r].b);
        wr(SCS_ADDR_PRESET, rows[r].c);
        adc(rows[r].ctrl[5] ? rows[r].c : 16'h4000);
        chk("speed mag", 32'(e < 0 ? -e : e), 32'(speed_mag_o));
        chk("speed rev", 32'(e < 0), 32'(speed_rev_o));
      end
      $display("row %0d done", r);
    end
    // reset values, then read-back of an extreme numerator
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("motor in reset", 32'h0, 32'(motor_on_o));
    do_reset();
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i], "reset reg");
    wr(SCS_ADDR_NUM1, 16'hffff);
    rd(SCS_ADDR_NUM1, 16'hffff, "num1 wide");
    $display("reset test done");
    // select ignored while dynamic gear is off, then switches numerator
    do_reset();
    wr(SCS_ADDR_NUM2, 16'd3);
    i_scs_host_model.switch_sel(1'b1);
    burst(4, 1'b1, 4, "dyn off");
    wr(SCS_ADDR_CTRL, 16'h0028);
    burst(4, 1'b1, 16, "num two");
    i_scs_host_model.switch_sel(1'b0);
    burst(2, 1'b1, 18, "num one");
    rd(SCS_ADDR_POSCNT, 16'd18, "pos count");
    $display("gear switch test done");
    // clamp overrides a live command
    do_reset();
    wr(SCS_ADDR_CTRL, 16'h0021);
    adc(16'h0100);
    @(posedge mclk_i);
    clamp_i <= 1'b1;
    adc(16'h0100);
    chk("clamp mag", 32'h0, 32'(speed_mag_o));
    @(posedge mclk_i);
    clamp_i <= 1'b0;
    // let the clamp release pass the pin synchroniser before the next sample
    repeat (2) @(posedge mclk_i);
    adc(16'h0100);
    chk("unclamp mag", 32'd300, 32'(speed_mag_o));
    burst(3, 1'b1, 0, "speed mode steps");
    wr(SCS_ADDR_CTRL, 16'h0026);
    adc(16'h0100);
    chk("torque mag", 32'h0, 32'(speed_mag_o));
    $display("clamp test done");
    // enable and alarm gate the motor and the pulse path
    do_reset();
    son_i <= 1'b0;
    burst(3, 1'b1, 0, "disabled steps");
    chk("motor off", 32'h0, 32'({motor_on_o, run_led_o}));
    @(posedge mclk_i);
    son_i <= 1'b1;
    alarm_i <= 1'b1;
    adc(16'h0);
    chk("alarm motor", 32'h0, 32'({motor_on_o, run_led_o}));
    @(posedge mclk_i);
    alarm_i <= 1'b0;
    adc(16'h0);
    chk("motor on", 32'h3, 32'({motor_on_o, run_led_o}));
    $display("enable test done");
    // travel limits block motion into them unless ignored
    @(posedge mclk_i);
    fwd_lim_i <= 1'b1;
    burst(3, 1'b1, 0, "into fwd limit");
    burst(3, 1'b0, -3, "away from limit");
    @(posedge mclk_i);
    rev_lim_i <= 1'b1;
    wr(SCS_ADDR_CTRL, 16'h0060);
    burst(3, 1'b1, 0, "limits ignored");
    rd(SCS_ADDR_STATUS, 16'h0031, "status");
    wr(SCS_ADDR_CTRL, 16'h0021);
    adc(16'h0100);
    chk("limit mag", 32'h0, 32'(speed_mag_o));
    $display("limit test done");
    results();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end
endmodule : servo_command_scaling_bench

`default_nettype wire
